// file: flmc_top.sv
// Flash LED mode controller: pin decode, register bank, fault and interrupt
`include "flmc_defs.svh"
module flmc_top
   import flmc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        clk_en,
   input  wire logic        wb_cyc,
   input  wire logic        wb_stb,
   input  wire logic        wb_we,
   input  wire logic [7:0]  wb_adr,
   input  wire logic [3:0]  wb_sel,
   input  wire logic [31:0] wb_dat_w,
   output logic [31:0]      wb_dat_r,
   output logic             wb_ack,
   input  wire logic        interface_select,
   input  wire logic        mode_pin_high,
   input  wire logic        mode_pin_low,
   output logic             sda_out,
   output logic             sda_oe_n,
   input  wire logic        enable_pin,
   input  wire logic        strobe_input,
   input  wire logic        indicator_current_set_pin,
   input  wire logic        torch_current_set_pin,
   input  wire logic        flash_current_set_pin,
   input  wire logic        ov_detect,
   output logic             int_out,
   output logic             int_oe_n,
   output logic             irq,
   output flmc_main_t       main_mode,
   output logic             converter_on,
   output logic             indicator_on,
   output logic [2:0]       indicator_current_code,
   output logic [4:0]       main_led_current_code,
   output logic             ext_scale
);
   localparam int PIN_N = 9;

   function automatic logic at(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   function automatic flmc_main_t main_of(input logic [4:0] c, input logic fire);
      if (c == 5'h00) return MAIN_OFF;
      if (c <= `FLMC_TORCH_MAX) return MAIN_TORCH;
      return fire ? MAIN_FLASH : MAIN_ARMED;
   endfunction

   // Pin synchronisers
   wire  [PIN_N-1:0] pin_raw = {ov_detect, flash_current_set_pin, torch_current_set_pin,
                                indicator_current_set_pin, strobe_input, enable_pin,
                                mode_pin_low, mode_pin_high, interface_select};
   logic [PIN_N-1:0] pin_s;

   for (genvar i = 0; i < PIN_N; i++) begin : g_sync
      logic s1_q;
      logic s2_q;
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
         end else if (clk_en) begin
            s1_q <= pin_raw[i];
            s2_q <= s1_q;
         end
      end
      assign pin_s[i] = s2_q;
   end

   wire interface_select_s = pin_s[0];
   wire hi_s   = pin_s[1];
   wire lo_s   = pin_s[2];
   wire en_s   = pin_s[3];
   wire str_s  = pin_s[4];
   wire indicator_current_set_pin_s = pin_s[5];
   wire torch_current_set_pin_s = pin_s[6];
   wire flash_current_set_pin_s = pin_s[7];
   wire ov_s   = pin_s[8];
   wire serial = ~interface_select_s; // see R1

   // Mode pins must hold one value for a few cycles before they are decoded;
   // serial traffic reads as 00 so that entering hardwired mode starts disabled
   wire  [1:0] hw_raw = serial ? 2'h0 : {hi_s, lo_s}; // see R18
   logic [1:0] hw_cand_q;
   logic [1:0] hw_code_q;
   logic [2:0] hw_cnt_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hw_cand_q <= 2'h0;
         hw_code_q <= 2'h0;
         hw_cnt_q  <= 3'h0;
      end else if (clk_en) begin
         if (hw_raw != hw_cand_q) begin
            hw_cand_q <= hw_raw; // see R18
            hw_cnt_q  <= 3'h0;
         end else if (hw_cnt_q != `FLMC_MODE_STABLE) begin
            hw_cnt_q <= hw_cnt_q + 3'h1;
         end else begin
            hw_code_q <= hw_cand_q; // see R18
         end
      end
   end

   // Serial slave on the shared mode pins
   flmc_wr_t   i2c_wr;
   logic [1:0] sub_idx;
   logic       sda_low;
   wire  [7:0] dev_w [4];

   flmc_i2c u_i2c (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .active  (serial),
      .scl_s   (hi_s),
      .sda_s   (lo_s),
      .rd_data (dev_w[sub_idx]),
      .wr      (i2c_wr),
      .sub_idx (sub_idx),
      .sda_low (sda_low)
   );

   assign sda_out  = 1'b0;
   assign sda_oe_n = ~sda_low; // see R1

   // Bus decode
   logic       wb_ack_q;
   logic [31:0] wb_dat_q;
   wire        wb_req  = wb_cyc & wb_stb & ~wb_ack_q;
   wire        wb_wr   = wb_req & wb_we & wb_sel[0];
   wire        dev_hit = wb_adr[7:4] == `FLMC_OFF_DEV_HI;
   wire [1:0]  wb_idx  = wb_adr[3:2];

   // Device registers; bus write wins over a serial write in the same cycle
   for (genvar r = 0; r < 3; r++) begin : g_reg
      logic [7:0] v_q;
      wire        wbw = wb_wr & dev_hit & (wb_idx == 2'(r));
      wire        srw = i2c_wr.valid & (i2c_wr.idx == 2'(r)); // see R6
      always_ff @(posedge clk) begin
         if (sys_rst) v_q <= `FLMC_REG_RST;
         else if (clk_en && wbw) v_q <= wb_dat_w[7:0];
         else if (clk_en && srw) v_q <= i2c_wr.data;
      end
      assign dev_w[r] = v_q;
   end

   // Overvoltage fault, cleared by a zero to the output select or by mode pins 00
   logic fault_q;
   wire  clr_sw = (wb_wr & dev_hit & (wb_idx == `FLMC_IDX_OUTSEL) & (wb_dat_w[7:0] == 8'h00))
                | (i2c_wr.valid & (i2c_wr.idx == `FLMC_IDX_OUTSEL) & (i2c_wr.data == 8'h00));
   wire  clr_hw = ~serial & (hw_code_q == 2'h0);
   wire  fault_d = ov_s | (fault_q & ~(clr_sw | clr_hw)); // see R4

   always_ff @(posedge clk) begin
      if (sys_rst) fault_q <= 1'b0;
      else if (clk_en) fault_q <= fault_d;
   end

   assign dev_w[`FLMC_IDX_FAULT] = {7'h00, fault_q}; // see R7 R8

   assign int_out  = 1'b0;
   assign int_oe_n = ~fault_q; // see R17

   // Mode and current code selection
   wire        sw_strobe = dev_w[`FLMC_IDX_CONFIG][`FLMC_SWSTR_BIT];
   wire        strobe_on = str_s | sw_strobe; // see R13
   wire        live      = en_s & ~fault_q; // see R15 R4
   logic [2:0] ind_c;
   logic [4:0] main_c;
   logic       ext_c;

   always_comb begin
      ind_c  = 3'h0;
      main_c = 5'h00;
      ext_c  = 1'b0;
      if (serial) begin
         ind_c  = dev_w[`FLMC_IDX_OUTSEL][2:0];
         main_c = dev_w[`FLMC_IDX_OUTSEL][7:3];
         ext_c  = ~flash_current_set_pin_s; // see R14
      end else begin
         unique case (hw_code_q) // see R2
            2'h0: ;
            2'h1: begin
               ind_c = `FLMC_DEF_IND; // see R3
               ext_c = ~indicator_current_set_pin_s;
            end
            2'h2: begin
               main_c = `FLMC_DEF_TORCH; // see R3
               ext_c  = ~torch_current_set_pin_s;
            end
            2'h3: begin
               main_c = `FLMC_DEF_FLASH; // see R3
               ext_c  = ~flash_current_set_pin_s;
            end
         endcase
      end
   end

   // Strobe counts only in serial mode
   wire flmc_main_t mode_c = main_of(main_c, serial ? strobe_on : 1'b1); // see R11 R12 R16
   wire             conv_c = (mode_c == MAIN_TORCH) | (mode_c == MAIN_FLASH);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         main_mode              <= MAIN_OFF;
         converter_on           <= 1'b0;
         indicator_on           <= 1'b0;
         indicator_current_code <= 3'h0;
         main_led_current_code  <= 5'h00;
         ext_scale              <= 1'b0;
      end else if (clk_en) begin
         main_mode              <= live ? mode_c : MAIN_OFF; // see R15
         converter_on           <= live & conv_c; // see R4 R13
         indicator_on           <= live & (ind_c != 3'h0); // see R9 R10
         indicator_current_code <= ind_c; // see R10
         main_led_current_code  <= main_c; // see R14
         ext_scale              <= ext_c;
      end
   end

   // Interrupt status, write one to clear; a new event wins over the clear
   logic [1:0] irq_stat_q;
   logic [1:0] irq_mask_q;
   wire  [1:0] irq_ev  = {i2c_wr.valid, ov_s & ~fault_q};
   wire  [1:0] irq_w1c = (wb_wr & at(wb_adr, `FLMC_OFF_IRQ_STAT)) ? wb_dat_w[1:0] : 2'h0;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_stat_q <= `FLMC_IRQ_RST;
         irq_mask_q <= `FLMC_IRQ_RST;
      end else if (clk_en) begin
         irq_stat_q <= irq_ev | (irq_stat_q & ~irq_w1c);
         if (wb_wr && at(wb_adr, `FLMC_OFF_IRQ_MASK)) irq_mask_q <= wb_dat_w[1:0];
      end
   end

   assign irq = |(irq_stat_q & irq_mask_q);

   // Read mux and single-cycle acknowledge
   wire [31:0] rd_c = dev_hit ? {24'h0, dev_w[wb_idx]}
                    : at(wb_adr, `FLMC_OFF_IRQ_STAT) ? {30'h0, irq_stat_q}
                    : at(wb_adr, `FLMC_OFF_IRQ_MASK) ? {30'h0, irq_mask_q}
                    : at(wb_adr, `FLMC_OFF_STATE) ? {26'h0, en_s, interface_select_s, hw_code_q, main_mode}
                    : 32'h0;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wb_ack_q <= 1'b0;
         wb_dat_q <= 32'h0;
      end else if (clk_en) begin
         wb_ack_q <= wb_req;
         if (wb_req && !wb_we) wb_dat_q <= rd_c;
      end
   end

   assign wb_ack   = wb_ack_q;
   assign wb_dat_r = wb_dat_q;

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   wb_ack_pulse_a: assert property (clk_en && wb_ack |=> !wb_ack)
      else $error("ack held longer than one cycle");
   sel_release_a: assert property (clk_en && !serial |=> sda_oe_n) // see R1
      else $error("data line driven in hardwired mode");
   hw_torch_a: assert property (clk_en && !serial && live && hw_code_q == 2'h2 |=> // see R2
      main_mode == MAIN_TORCH && main_led_current_code == `FLMC_DEF_TORCH)
      else $error("hardwired torch not decoded");
   hw_ind_default_a: assert property (clk_en && !serial && live && hw_code_q == 2'h1 |=> // see R3
      indicator_on && indicator_current_code == `FLMC_DEF_IND)
      else $error("hardwired indicator default wrong");
   ov_shutdown_a: assert property (clk_en && ov_s ##1 clk_en |=> !converter_on) // see R4
      else $error("converter not off after overvoltage");
   ind_off_a: assert property (clk_en && serial && ind_c == 3'h0 |=> !indicator_on) // see R9
      else $error("indicator on with zero code");
   ind_level_a: assert property (clk_en && serial && live && ind_c != 3'h0 |=> // see R10
      indicator_on && indicator_current_code == $past(ind_c))
      else $error("indicator code not applied");
   main_off_a: assert property (clk_en && serial && main_c == 5'h00 |=> !converter_on) // see R11
      else $error("main regulator on with zero code");
   torch_code_a: assert property (clk_en && serial && live && main_c != 5'h00 &&
      main_c <= `FLMC_TORCH_MAX |=> main_mode == MAIN_TORCH && converter_on) // see R12
      else $error("torch code not continuously on");
   flash_hold_a: assert property (clk_en && serial && main_c > `FLMC_TORCH_MAX && // see R13
      !strobe_on |=> !converter_on ##1 (main_mode != MAIN_FLASH || $past(strobe_on)))
      else $error("flash fired without strobe");
   hw_strobe_a: assert property (clk_en && !serial && live && hw_code_q == 2'h3 |=> // see R16
      main_mode == MAIN_FLASH)
      else $error("hardwired flash depends on strobe");
   enable_off_a: assert property (clk_en && !en_s |=> !converter_on && !indicator_on) // see R15
      else $error("outputs on while disabled");
   int_fall_a: assert property (clk_en && ov_s |=> !int_oe_n) // see R17
      else $error("interrupt not pulled low on fault");
   mode_filter_a: assert property ($changed(hw_code_q) |-> // see R18
      $past(hw_raw) == hw_code_q && $past(hw_raw, 2) == hw_code_q)
      else $error("mode changed without stable pins");

   torch_seen_c: cover property (converter_on && main_mode == MAIN_TORCH);
   flash_seen_c: cover property (converter_on && main_mode == MAIN_FLASH && serial);
   fault_seen_c: cover property (!int_oe_n ##[1:50] int_oe_n);
   ser_write_c: cover property (i2c_wr.valid);
endmodule // flmc_top

// file: flmc_defs.svh
// Constants of the flash LED mode controller
// Contract
// (R1) Interface select high: mode pins control; low: they are serial data and clock
// (R2) Hardwired mode pins decode 00 off, 01 indicator, 10 torch, 11 flash
// (R3) Hardwired modes take their own set pin; tied high gives 10/125/500 mA defaults
// (R4) Output above 10.15 V switches converter off and reports fault via pin and status
// (R5) Serial mode answers bus address 0x60, sent by host as write address byte
// (R6) Serial write: subaddress byte picks one of four registers, next byte stored there
// (R7) Serial read returns register picked by last subaddress; fault status is register three
// (R8) Register bit 0 is least significant, bit 7 most significant
// (R9) Indicator code zero turns the indicator regulator off
// (R10) Indicator codes 1 to 7 keep indicator on at 2.5 mA times code
// (R11) Main LED code zero keeps the high-power regulator off
// (R12) Main LED codes 1 to 11 give torch, continuously on, strobe ignored
// (R13) Main LED codes 12 to 31 stay off until pin or software strobe
// (R14) Flash set pin high: main current is 35 mA plus code times 15 mA
// (R15) Enable pin low disables the whole device; high turns it on; code only forces main_mode, converter_on and indicator_on off
// (R16) Strobe pin enables flash in serial mode only; ignored in hardwired mode
// (R17) Interrupt output is open-drain, active low, falls when a fault occurs
// (R18) Mode pins are synchronised and filtered before decoding
`ifndef FLMC_DEFS_SVH
`define FLMC_DEFS_SVH
`define FLMC_ADDR_BYTE    8'h60
`define FLMC_OFF_DEV_HI   4'h0
`define FLMC_OFF_IRQ_STAT 8'h10
`define FLMC_OFF_IRQ_MASK 8'h14
`define FLMC_OFF_STATE    8'h18
`define FLMC_REG_RST      8'h00
`define FLMC_IRQ_RST      2'h0
`define FLMC_IDX_OUTSEL   2'h0
`define FLMC_IDX_CONFIG   2'h1
`define FLMC_IDX_FAULT    2'h3
`define FLMC_SWSTR_BIT    0
`define FLMC_TORCH_MAX    5'h0b
`define FLMC_DEF_IND      3'h4
`define FLMC_DEF_TORCH    5'h06
`define FLMC_DEF_FLASH    5'h1f
`define FLMC_MODE_STABLE  3'h4
`endif

// file: flmc_pkg.sv
// Types shared by the flash LED mode controller
package flmc_pkg;
   typedef enum logic [1:0] {MAIN_OFF, MAIN_TORCH, MAIN_ARMED, MAIN_FLASH} flmc_main_t;
   typedef enum logic [2:0] {I2C_IDLE, I2C_RX, I2C_ACKW, I2C_ACK, I2C_TX, I2C_TXACK} flmc_i2c_st_t;
   typedef struct packed {
      logic       valid;
      logic [1:0] idx;
      logic [7:0] data;
   } flmc_wr_t;
endpackage

// file: flmc_i2c.sv
// Two-wire serial slave of the flash LED mode controller
`include "flmc_defs.svh"
module flmc_i2c
   import flmc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       clk_en,
   input  wire logic       active,
   input  wire logic       scl_s,
   input  wire logic       sda_s,
   input  wire logic [7:0] rd_data,
   output flmc_wr_t        wr,
   output logic [1:0]      sub_idx,
   output logic            sda_low
);
   flmc_i2c_st_t st_q;
   logic         scl_p_q;
   logic         sda_p_q;
   logic [7:0]   sh_q;
   logic [2:0]   cnt_q;
   logic         first_q;
   logic         sub_q;
   logic         rw_q;
   logic [1:0]   idx_q;
   flmc_wr_t     wr_q;

   wire       scl_rise  = scl_s & ~scl_p_q;
   wire       scl_fall  = ~scl_s & scl_p_q;
   wire       start     = scl_s & scl_p_q & sda_p_q & ~sda_s;
   wire       stop      = scl_s & scl_p_q & ~sda_p_q & sda_s;
   wire [7:0] byte_in   = {sh_q[6:0], sda_s};
   wire [7:0] addr_byte = `FLMC_ADDR_BYTE;
   wire       addr_ok   = byte_in[7:1] == addr_byte[7:1]; // see R5

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q    <= I2C_IDLE;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         sh_q    <= 8'h00;
         cnt_q   <= 3'h0;
         first_q <= 1'b0;
         sub_q   <= 1'b0;
         rw_q    <= 1'b0;
         idx_q   <= 2'h0;
         wr_q    <= '0;
      end else if (clk_en) begin
         scl_p_q    <= scl_s;
         sda_p_q    <= sda_s;
         wr_q.valid <= 1'b0;
         if (!active || stop) begin
            st_q <= I2C_IDLE;
         end else if (start) begin
            st_q    <= I2C_RX;
            cnt_q   <= 3'h0;
            first_q <= 1'b1;
            sub_q   <= 1'b0;
         end else begin
            unique case (st_q)
               I2C_IDLE: ;
               I2C_RX: if (scl_rise) begin
                  // Bits arrive most significant first, bit 7 down to bit 0
                  sh_q  <= byte_in; // see R8
                  cnt_q <= cnt_q + 3'h1;
                  if (cnt_q == 3'h7) begin
                     st_q    <= I2C_ACKW;
                     first_q <= 1'b0;
                     if (first_q) begin
                        rw_q <= byte_in[0];
                        if (!addr_ok) st_q <= I2C_IDLE; // see R5
                     end else if (!sub_q) begin
                        sub_q <= 1'b1;
                        idx_q <= byte_in[1:0]; // see R6
                     end else begin
                        wr_q <= '{valid: 1'b1, idx: idx_q, data: byte_in}; // see R6
                     end
                  end
               end
               I2C_ACKW: if (scl_fall) st_q <= I2C_ACK;
               I2C_ACK: if (scl_fall) begin
                  cnt_q <= 3'h0;
                  sh_q  <= rd_data; // see R7
                  st_q  <= rw_q ? I2C_TX : I2C_RX;
               end
               I2C_TX: if (scl_fall) begin
                  sh_q  <= {sh_q[6:0], 1'b0};
                  cnt_q <= cnt_q + 3'h1;
                  if (cnt_q == 3'h7) st_q <= I2C_TXACK;
               end
               I2C_TXACK: if (scl_rise) st_q <= I2C_IDLE;
               default: st_q <= I2C_IDLE;
            endcase
         end
      end
   end

   assign wr      = wr_q;
   assign sub_idx = idx_q;
   assign sda_low = (st_q == I2C_ACK) | ((st_q == I2C_TX) & ~sh_q[7]);
endmodule // flmc_i2c

// file: flmc_host.sv
// Host model: drives the mode pins in hardwired mode and masters the serial bus
module flmc_host (
   input  wire logic sda_oe_n,
   input  wire logic interface_select,
   output logic      mode_pin_high,
   output logic      mode_pin_low
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] hw_mode = 2'h0;
   logic       scl     = 1'b1;
   logic       sda_rel = 1'b1;
   // Pull-up on the data line: high unless a party pulls it low
   wire        line    = sda_rel & sda_oe_n;

   assign mode_pin_high = interface_select ? hw_mode[1] : scl;
   assign mode_pin_low  = interface_select ? hw_mode[0] : line;

   // Data changes mid-low, line sampled late in the high phase
   task automatic bit_io(input logic b, output logic s);
      scl = 1'b0;
      #31.25 sda_rel = b;
      #31.25 scl = 1'b1;
      #50 s = line;
      #12.5;
   endtask

   task automatic start;
      scl = 1'b0;
      #31.25 sda_rel = 1'b1;
      #31.25 scl = 1'b1;
      #62.5 sda_rel = 1'b0;
      #62.5;
   endtask

   // Clock is left high and still after the frame
   task automatic stop;
      scl = 1'b0;
      #31.25 sda_rel = 1'b0;
      #31.25 scl = 1'b1;
      #62.5 sda_rel = 1'b1;
      #62.5;
   endtask

   task automatic byte_wr(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask

   task automatic byte_rd(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(nack, s);
   endtask

   task automatic write_reg(input logic [7:0] adr, sub, dat, output logic [2:0] acks);
      start();
      byte_wr(adr, acks[2]);
      byte_wr(sub, acks[1]);
      byte_wr(dat, acks[0]);
      stop();
   endtask

   task automatic read_reg(input logic [7:0] sub, output logic [7:0] dat,
                           output logic [2:0] acks);
      start();
      byte_wr(8'h60, acks[2]);
      byte_wr(sub, acks[1]);
      start();
      byte_wr(8'h61, acks[0]);
      byte_rd(1'b1, dat);
      stop();
   endtask
endmodule // flmc_host

// file: flmc_tb.sv
// Testbench of the flash LED mode controller: bus tasks, pin and serial scenarios
module tb
   import flmc_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] dw = 32'h0, dat_r;
   logic        interface_select = 0, enable_pin = 0, strobe_input = 0, set_t = 1;
   logic        ov_detect = 0, ack, mph, mpl, sda_oe_n, int_oe_n, irq, conv, ind_on;
   logic        ext_scale, ce = 1;
   flmc_main_t  main_mode;
   logic [2:0]  icode;
   logic [4:0]  mcode;
   int          n_mismatch = 0, num_checks = 0;

   always #2.5 clk = ~clk;

   flmc_host u_host (.sda_oe_n(sda_oe_n), .interface_select(interface_select),
      .mode_pin_high(mph), .mode_pin_low(mpl));

   flmc_top uut (.clk(clk), .sys_rst(sys_rst), .clk_en(ce), .wb_cyc(cyc), .wb_stb(stb),
      .wb_we(we), .wb_adr(adr), .wb_sel(sel), .wb_dat_w(dw), .wb_dat_r(dat_r), .wb_ack(ack),
      .interface_select(interface_select), .mode_pin_high(mph), .mode_pin_low(mpl),
      .sda_out(), .sda_oe_n(sda_oe_n), .enable_pin(enable_pin), .strobe_input(strobe_input),
      .indicator_current_set_pin(1'b1), .torch_current_set_pin(set_t),
      .flash_current_set_pin(1'b1), .ov_detect(ov_detect), .int_out(), .int_oe_n(int_oe_n),
      .irq(irq), .main_mode(main_mode), .converter_on(conv), .indicator_on(ind_on),
      .indicator_current_code(icode), .main_led_current_code(mcode), .ext_scale(ext_scale));

   task automatic give_verdict;
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic timeout;
      n_mismatch++;
      give_verdict();
   endtask

   // One classic cycle; entered just after a rising edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dw  <= d;
      sel <= 4'hf;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      if (n >= 20) timeout();
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(what, q, e);
   endtask

   task automatic outs(input logic [11:0] e);
      chk("outputs", {20'h0, main_mode, conv, ind_on, icode, mcode}, {20'h0, e});
   endtask

   task automatic wait_int(input logic lvl);
      int n;
      for (n = 0; n < 12 && int_oe_n !== lvl; n++) @(posedge clk);
      if (n >= 12) timeout();
   endtask

   initial begin
      logic [4:0]  mc;
      logic [2:0]  ic;
      logic [2:0]  acks;
      logic [7:0]  rb;
      flmc_main_t  mm;
      static logic [4:0] mc_tab [6] = '{5'h00, 5'h01, 5'h0b, 5'h0c, 5'h1f, 5'h00};
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      enable_pin <= 1'b1;
      repeat (4) @(posedge clk);
      chk("int_oe_n reset", int_oe_n, 1'b1);
      rd(8'h00, 32'h0, "out_sel reset");
      rd(8'h10, 32'h0, "irq stat reset");
      for (int i = 0; i < 6; i++) begin
         mc = mc_tab[i];
         ic = 3'(i * 3);
         wr(8'h00, {24'h0, mc, ic});
         repeat (4) @(posedge clk);
         mm = (mc == 5'h00) ? MAIN_OFF : ((mc <= 5'h0b) ? MAIN_TORCH : MAIN_ARMED);
         outs({mm, mm == MAIN_TORCH, ic != 3'h0, ic, mc});
      end
      wr(8'h00, {24'h0, 5'h0c, 3'h0});
      strobe_input <= 1'b1;
      repeat (6) @(posedge clk);
      outs({MAIN_FLASH, 2'b10, 3'h0, 5'h0c});
      strobe_input <= 1'b0;
      wr(8'h04, 32'h1);
      repeat (4) @(posedge clk);
      outs({MAIN_FLASH, 2'b10, 3'h0, 5'h0c});
      wr(8'h04, 32'h0);
      wr(8'h00, {24'h0, 5'h05, 3'h2});
      strobe_input <= 1'b1;
      repeat (6) @(posedge clk);
      outs({MAIN_TORCH, 2'b11, 3'h2, 5'h05});
      // Clock enable low: the enable pin change must not reach the outputs
      ce <= 1'b0;
      enable_pin <= 1'b0;
      repeat (6) @(posedge clk);
      outs({MAIN_TORCH, 2'b11, 3'h2, 5'h05});
      ce <= 1'b1;
      enable_pin <= 1'b0;
      repeat (6) @(posedge clk);
      chk("gated", {conv, ind_on}, 2'b00);
      enable_pin <= 1'b1;
      strobe_input <= 1'b0;
      // Overvoltage fault: latch, report, read-only status, clear
      wr(8'h14, 32'h1);
      ov_detect <= 1'b1;
      wait_int(1'b0);
      repeat (2) @(posedge clk);
      chk("fault outputs", {conv, irq}, 2'b01);
      u_host.read_reg(8'h03, rb, acks);
      @(posedge clk);
      chk("serial fault", {acks, rb}, {3'b111, 8'h01});
      wr(8'h0c, 32'h0);
      rd(8'h0c, 32'h1, "fault reg");
      ov_detect <= 1'b0;
      repeat (4) @(posedge clk);
      wr(8'h00, 32'h0);
      wait_int(1'b1);
      rd(8'h0c, 32'h0, "fault cleared");
      wr(8'h10, 32'h1);
      chk("irq cleared", irq, 1'b0);
      rd(8'h40, 32'h0, "unmapped");
      // Hardwired mode, strobe held high while each of the four mode codes is stepped through
      interface_select <= 1'b1;
      set_t <= 1'b0;
      strobe_input <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         u_host.hw_mode <= 2'(m);
         repeat (5) @(posedge clk);
         if (m == 0) chk("mode entry", conv, 1'b0);
         repeat (9) @(posedge clk);
         case (m)
            0: outs({MAIN_OFF, 2'b00, 3'h0, 5'h00});
            1: outs({MAIN_OFF, 2'b01, 3'h4, 5'h00});
            2: outs({MAIN_TORCH, 2'b10, 3'h0, 5'h06});
            default: outs({MAIN_FLASH, 2'b10, 3'h0, 5'h1f});
         endcase
         chk("ext_scale", ext_scale, m == 2);
      end
      u_host.hw_mode <= 2'h0;
      strobe_input <= 1'b0;
      interface_select <= 1'b0;
      repeat (20) @(posedge clk);
      // Serial link
      u_host.write_reg(8'h60, 8'h00, 8'h6b, acks);
      @(posedge clk);
      chk("serial wr acks", acks, 3'b111);
      rd(8'h00, 32'h6b, "serial stored");
      rd(8'h10, 32'h2, "irq serial");
      outs({MAIN_ARMED, 2'b01, 3'h3, 5'h0d});
      u_host.read_reg(8'h00, rb, acks);
      @(posedge clk);
      chk("serial rd", {acks, rb}, {3'b111, 8'h6b});
      u_host.write_reg(8'h62, 8'h00, 8'h00, acks);
      @(posedge clk);
      chk("wrong adr acks", acks, 3'b000);
      rd(8'h00, 32'h6b, "not stored");
      give_verdict();
   end
endmodule // tb
